// ==== irq_params.svh ====
`ifndef IRQ_PARAMS_SVH
`define IRQ_PARAMS_SVH

`define EN_OFS      12'h300
`define STAT_OFS    12'h304
`define MAP0_OFS    12'h308
`define MAP1_OFS    12'h30C
`define MAP2_OFS    12'h340
`define ADDR_W      12

`define STAT_VALID  32'h00FFF7FF
`define MAP0_VALID  32'h77777777
`define MAP1_VALID  32'h77770777
`define MAP2_VALID  32'h77777777
`define REG_RST     32'h00000000

`define LM_LSB      20
`define MBOX_LSB    16
`define BIT_ACFAIL  15
`define BIT_SYSFAIL 14
`define BIT_SWINT   13
`define BIT_SWIACK  12
`define BIT_VME_BUS_ERROR_IRQ    10
`define BIT_PCI_BUS_ERROR_IRQ    9
`define BIT_DMA     8
`define VIRQ_LSB    1
`define BIT_BUS_OWNERSHIP_IRQ    0

`define NSRC        24
`define NPIN        8
`define FIELD_STEP  4
`define DEST_W      3

`define RESP_OK     2'h0
`define RESP_DECERR 2'h3

`endif

// ==== irq_pkg.sv ====
package irq_pkg;

   typedef logic [31:0] word_t;
   typedef logic [2:0]  dest_t;

   typedef enum logic {
      BUS_IDLE = 1'b0,
      BUS_DONE = 1'b1
   } bus_state_t;

endpackage

// ==== route_if.sv ====
interface route_if;
   import irq_pkg::*;

   logic [23:0] active;
   dest_t       dest [24];
   logic [7:0]  pins;

   modport ctrl (output active, output dest, input pins);
   modport rtr  (input active, input dest, output pins);
endinterface

// ==== irq_router.sv ====
`include "irq_params.svh"

module irq_router
   import irq_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   route_if.rtr     rif
);

   // ---------------------------------------------------------------
   // Per-pin match of every source that is pending and enabled.
   // ---------------------------------------------------------------
   logic [`NSRC-1:0] match [`NPIN];
   logic [`NPIN-1:0] pins_r;

   genvar p;
   genvar s;
   generate
      for (p = 0; p < `NPIN; p++) begin : g_pin
         for (s = 0; s < `NSRC; s++) begin : g_src
            assign match[p][s] = rif.active[s] &
                                 (rif.dest[s] == dest_t'(p));
         end
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               pins_r[p] <= 1'b0;
            end else begin
               pins_r[p] <= |match[p];
            end
         end
      end
   endgenerate

   assign rif.pins = pins_r;

endmodule

// ==== pci_side_interrupt_status_map.sv ====
// Our own choice: the Avalon-MM interface to the registers.
`include "irq_params.svh"

// Operation
// - Four location monitor status bits, reset zero, read one when active.
// - Four mailbox status bits, reset zero, read one when pending.
// - Backplane failure status bits read one while that failure is active.
// - Status bits for local software and remote software-ack interrupts.
// - Separate remote error, local error and DMA bits, reset zero.
// - One status bit per remote interrupt level seven to one.
// - Bus ownership status bit set on gain, cleared by writing one.
// - Non-failure status bits catch the event edge and stay set afterwards.
// - Writing one clears a status bit; writing zero keeps it.
// - Clearing a status bit leaves the originating source untouched.
// - Failure bits are set by pin level; clearing while asserted has no effect.
// - Each route code picks one of eight outputs, code n selects output n.
// - First map holds reset-zero read/write routes for levels seven to one.
// - First map also routes the bus ownership interrupt.
// - No new vector at a level until that level's status bit is cleared.
module pci_side_interrupt_status_map
   import irq_pkg::*;
(
   input  wire logic               mclk,
   input  wire logic               rst_b,
   input  wire logic [`ADDR_W-1:0] avs_address,
   input  wire logic               avs_read,
   input  wire logic               avs_write,
   input  wire logic [31:0]        avs_writedata,
   input  wire logic [3:0]         avs_byteenable,
   output logic      [31:0]        avs_readdata,
   output logic                    avs_waitrequest,
   output logic      [1:0]         avs_response,
   input  wire logic [3:0]         location_monitor_evt,
   input  wire logic [3:0]         mailbox_evt,
   input  wire logic               acfail_b,
   input  wire logic               sysfail_b,
   input  wire logic               vme_software_ack_irq,
   input  wire logic               vme_bus_error_irq,
   input  wire logic               pci_bus_error_irq,
   input  wire logic               dma_done_evt,
   input  wire logic [7:1]         vme_level_irqs,
   input  wire logic               bus_ownership_irq,
   output logic      [7:1]         vme_level_fetch_ok,
   output logic      [7:0]         host_irq_out,
   output logic                    irq
);

   // ---------------------------------------------------------------
   // Register storage and shared nets.
   // ---------------------------------------------------------------
   word_t      stat_r;
   word_t      stat_nxt;
   word_t      en_r;
   word_t      map0_r;
   word_t      map1_r;
   word_t      map2_r;
   word_t      rdata_r;
   logic [1:0] resp_r;
   bus_state_t bus_r;
   logic       req;
   logic       wr_go;
   logic       rd_take;
   logic       hit_en;
   logic       hit_stat;
   logic       hit_map0;
   logic       hit_map1;
   logic       hit_map2;
   logic       hit_any;
   word_t      be_mask;
   word_t      wmask;
   word_t      clr_v;
   word_t      src_v;
   word_t      src_q;
   word_t      set_v;
   logic       swint_q;
   logic [1:0] fail_lvl;

   // ---------------------------------------------------------------
   // Carrier between the status logic and the router.
   // ---------------------------------------------------------------
   route_if rif ();

   // ---------------------------------------------------------------
   // Merge of a write into a register through the byte lanes.
   // ---------------------------------------------------------------
   function automatic word_t merge(word_t old_v, word_t wd, word_t bm,
                                   word_t valid);
      merge = ((old_v & ~bm) | (wd & bm)) & valid;
   endfunction

   // ---------------------------------------------------------------
   // Avalon-MM slave handshake.
   // ---------------------------------------------------------------
   assign req = avs_read | avs_write;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         bus_r <= BUS_IDLE;
      end else begin
         case (bus_r)
            BUS_IDLE: begin
               if (req) begin
                  bus_r <= BUS_DONE;
               end
            end
            BUS_DONE: begin
               bus_r <= BUS_IDLE;
            end
            default: begin
               bus_r <= BUS_IDLE;
            end
         endcase
      end
   end

   assign avs_waitrequest = req & (bus_r != BUS_DONE);
   assign wr_go           = avs_write & (bus_r == BUS_DONE);
   assign rd_take         = avs_read & (bus_r == BUS_IDLE);

   // ---------------------------------------------------------------
   // Address decode and byte lanes.
   // ---------------------------------------------------------------
   assign hit_en   = (avs_address == `EN_OFS);
   assign hit_stat = (avs_address == `STAT_OFS);
   assign hit_map0 = (avs_address == `MAP0_OFS);
   assign hit_map1 = (avs_address == `MAP1_OFS);
   assign hit_map2 = (avs_address == `MAP2_OFS);
   assign hit_any  = hit_en | hit_stat | hit_map0 | hit_map1 | hit_map2;

   assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wmask   = avs_writedata & be_mask;

   // ---------------------------------------------------------------
   // Read data and response, captured one edge before the answer.
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata_r <= `REG_RST;
      end else if (rd_take) begin
         if (hit_en) begin
            rdata_r <= en_r;
         end else if (hit_stat) begin
            rdata_r <= stat_r;
         end else if (hit_map0) begin
            rdata_r <= map0_r;
         end else if (hit_map1) begin
            rdata_r <= map1_r;
         end else if (hit_map2) begin
            rdata_r <= map2_r;
         end else begin
            rdata_r <= `REG_RST;
         end
      end
   end

   // ---------------------------------------------------------------
   // Response code, decode error on an unmapped address.
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         resp_r <= `RESP_OK;
      end else if (bus_r == BUS_IDLE && req) begin
         resp_r <= hit_any ? `RESP_OK : `RESP_DECERR;
      end
   end

   assign avs_readdata = rdata_r;
   assign avs_response = resp_r;

   // ---------------------------------------------------------------
   // Backplane failure pins: three-stage sampling, agreement filter.
   // ---------------------------------------------------------------
   logic [1:0] pin_b;
   assign pin_b = {acfail_b, sysfail_b};

   genvar k;
   generate
      for (k = 0; k < 2; k++) begin : g_fail
         logic s1_r;
         logic s2_r;
         logic s3_r;
         logic lvl_r;
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               s1_r <= 1'b1;
               s2_r <= 1'b1;
               s3_r <= 1'b1;
            end else begin
               s1_r <= pin_b[k];
               s2_r <= s1_r;
               s3_r <= s2_r;
            end
         end
         always_ff @(posedge mclk) begin
            if (!rst_b) begin
               lvl_r <= 1'b0;
            end else if (s2_r == s3_r) begin
               lvl_r <= ~s3_r;
            end
         end
         assign fail_lvl[k] = lvl_r;
      end
   endgenerate

   // ---------------------------------------------------------------
   // Event sources gathered in status layout.
   // ---------------------------------------------------------------
   always_comb begin
      src_v = `REG_RST;
      src_v[`LM_LSB +: 4]   = location_monitor_evt;
      src_v[`MBOX_LSB +: 4] = mailbox_evt;
      src_v[`BIT_SWIACK]    = vme_software_ack_irq;
      src_v[`BIT_VME_BUS_ERROR_IRQ]      = vme_bus_error_irq;
      src_v[`BIT_PCI_BUS_ERROR_IRQ]      = pci_bus_error_irq;
      src_v[`BIT_DMA]       = dma_done_evt;
      src_v[`VIRQ_LSB +: 7] = vme_level_irqs;
      src_v[`BIT_BUS_OWNERSHIP_IRQ]      = bus_ownership_irq;
   end

   // ---------------------------------------------------------------
   // Previous source levels for edge detection.
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         src_q <= `REG_RST;
      end else begin
         src_q <= src_v;
      end
   end

   // ---------------------------------------------------------------
   // Previous software enable level for its rising edge.
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         swint_q <= 1'b0;
      end else begin
         swint_q <= en_r[`BIT_SWINT];
      end
   end

   // ---------------------------------------------------------------
   // Set terms from event edges and failure levels.
   // ---------------------------------------------------------------
   always_comb begin
      set_v = src_v & ~src_q;
      set_v[`BIT_ACFAIL]  = fail_lvl[1];
      set_v[`BIT_SYSFAIL] = fail_lvl[0];
      set_v[`BIT_SWINT]   = en_r[`BIT_SWINT] & ~swint_q;
   end

   // ---------------------------------------------------------------
   // Status register, write one to clear, set wins over clear.
   // ---------------------------------------------------------------
   assign clr_v = (wr_go && hit_stat) ? wmask : `REG_RST;

   always_comb begin
      stat_nxt = ((stat_r & ~clr_v) | set_v) & `STAT_VALID;
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         stat_r <= `REG_RST;
      end else begin
         stat_r <= stat_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Enable register, same layout as the status register.
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         en_r <= `REG_RST;
      end else if (wr_go && hit_en) begin
         en_r <= merge(en_r, avs_writedata, be_mask, `STAT_VALID);
      end
   end

   // ---------------------------------------------------------------
   // Route map registers.
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         map0_r <= `REG_RST;
      end else if (wr_go && hit_map0) begin
         map0_r <= merge(map0_r, avs_writedata, be_mask,
                         `MAP0_VALID);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         map1_r <= `REG_RST;
      end else if (wr_go && hit_map1) begin
         map1_r <= merge(map1_r, avs_writedata, be_mask, `MAP1_VALID);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         map2_r <= `REG_RST;
      end else if (wr_go && hit_map2) begin
         map2_r <= merge(map2_r, avs_writedata, be_mask, `MAP2_VALID);
      end
   end

   // ---------------------------------------------------------------
   // Routing of pending enabled sources to the local outputs.
   // ---------------------------------------------------------------
   logic [95:0] map_all;
   assign map_all = {map2_r, map1_r, map0_r};

   assign rif.active = stat_r[`NSRC-1:0] & en_r[`NSRC-1:0];

   genvar g;
   generate
      for (g = 0; g < `NSRC; g++) begin : g_dest
         assign rif.dest[g] =
            map_all[g*`FIELD_STEP +: `DEST_W];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Router that combines the sources per local output.
   // ---------------------------------------------------------------
   irq_router u_router (
      .mclk  (mclk),
      .rst_b (rst_b),
      .rif   (rif)
   );

   // ---------------------------------------------------------------
   // Local outputs and the summary interrupt level.
   // ---------------------------------------------------------------
   assign host_irq_out = rif.pins;
   assign irq          = |rif.active;

   // ---------------------------------------------------------------
   // Vector fetch permission per remote level.
   // ---------------------------------------------------------------
   assign vme_level_fetch_ok = ~stat_r[`VIRQ_LSB +: 7];

endmodule

// ==== irq_asserts.sv ====
`include "irq_params.svh"
module irq_asserts
   import irq_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic [11:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  avs_response,
   input wire logic [7:1]  vme_level_irqs,
   input wire logic [7:1]  vme_level_fetch_ok,
   input wire logic [7:0]  host_irq_out,
   input wire logic        irq
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Port checks.
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic mapped;
   assign mapped = avs_address inside {`EN_OFS, `STAT_OFS, `MAP0_OFS,
                                       `MAP1_OFS, `MAP2_OFS};
   a_one_wait: assert property ((avs_read || avs_write)
      && avs_waitrequest |=> !avs_waitrequest) else $error("Bad wait.");
   a_idle_ready: assert property (!(avs_read || avs_write)
      |-> !avs_waitrequest) else $error("Idle wait.");
   a_unmapped_read: assert property (avs_read && !avs_waitrequest
      && !mapped |-> avs_response == `RESP_DECERR && avs_readdata == '0)
      else $error("Unmapped read.");
   a_mapped_ok: assert property (avs_read && !avs_waitrequest
      && mapped |-> avs_response == `RESP_OK) else $error("Bad response.");
   a_level_hold: assert property ($rose(vme_level_irqs[7])
      |-> ##[1:3] !vme_level_fetch_ok[7]) else $error("Level not held.");
   a_level_keep: assert property (!vme_level_fetch_ok[7]
      && !avs_write |=> !vme_level_fetch_ok[7]) else $error("Level lost.");
   a_pin_follow: assert property ((|host_irq_out) == $past(irq))
      else $error("Pins do not follow irq.");
   a_irq_sticky: assert property (irq && !avs_write |=> irq)
      else $error("Irq dropped.");
endmodule
bind pci_side_interrupt_status_map irq_asserts u_asrt (.mclk, .rst_b,
   .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
   .avs_response, .vme_level_irqs, .vme_level_fetch_ok, .host_irq_out,
   .irq);

// ==== host_intc.sv ====
module host_intc (
   input wire logic       mclk,
   input wire logic       rst_b,
   input wire logic [7:0] lines,
   input wire logic       ack,
   output logic     [7:0] seen_r
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Host latches its interrupt lines.
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b || ack) begin
         seen_r <= 8'h00;
      end else begin
         seen_r <= seen_r | lines;
      end
   end
endmodule

// ==== tb_top.sv ====
`include "irq_params.svh"
module tb_top
   import irq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // Stimulus and checks.
   // ----------------------------------------
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        rd, wr, wq, irq, ack;
   logic [11:0] addr;
   logic [1:0]  rsp, resp;
   logic [7:1]  fok;
   logic [7:0]  pins, seen;
   logic [3:0]  be = 4'hF;
   word_t       wdata, rdv, rdata, src, r;
   word_t       vm = `STAT_VALID;
   logic [31:0] rng = 32'h0000005C;
   int          bad_count, tests_run;
   dest_t       d;
   logic [11:0] regs [5] = '{`EN_OFS, `STAT_OFS, `MAP0_OFS, `MAP1_OFS,
                             `MAP2_OFS};

   pci_side_interrupt_status_map DUT (
      .mclk, .rst_b, .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdv),
      .avs_waitrequest(wq), .avs_response(rsp),
      .location_monitor_evt(src[23:20]), .mailbox_evt(src[19:16]),
      .acfail_b(~src[15]), .sysfail_b(~src[14]),
      .vme_software_ack_irq(src[12]), .vme_bus_error_irq(src[10]),
      .pci_bus_error_irq(src[9]), .dma_done_evt(src[8]),
      .vme_level_irqs(src[7:1]), .bus_ownership_irq(src[0]),
      .vme_level_fetch_ok(fok), .host_irq_out(pins), .irq);
   host_intc host (.mclk, .rst_b, .lines(pins), .ack, .seen_r(seen));

   always #2.5 mclk = ~mclk;

   function automatic word_t xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic logic [11:0] map_of(int b);
      return b < 8 ? `MAP0_OFS : b < 16 ? `MAP1_OFS : `MAP2_OFS;
   endfunction
   function automatic word_t fok_of(int b);
      return 32'hFE & ~(32'h1 << b);
   endfunction

   task automatic conclude();
      $display("Counts: bad %0d of %0d", bad_count, tests_run);
      if (bad_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input word_t got, input word_t exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input word_t v);
      @(posedge mclk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= v;
      do @(posedge mclk); while (wq !== 1'b0);
      rdata = rdv;
      resp = rsp;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [11:0] a, input word_t e);
      bus(1'b0, a, '0);
      chk(rdata, e);
   endtask
   task automatic wrc(input logic [11:0] a, input word_t v, input word_t e);
      bus(1'b1, a, v);
      rdc(a, e);
   endtask

   initial begin
      repeat (20000) @(posedge mclk);
      bad_count++;
      conclude();
   end

   initial begin
      {rd, wr, ack, addr, wdata, src} = '0;
      repeat (20) @(posedge mclk);
      rst_b <= 1'b1;
      foreach (regs[i]) rdc(regs[i], '0);
      rdc(12'h3F8, '0);
      chk({30'h0, resp}, {30'h0, `RESP_DECERR});
      for (int i = 0; i < 4; i++) begin
         r = xs() & 32'h11111111;
         wrc(`MAP0_OFS, r, r);
         r = xs();
         wrc(`MAP1_OFS, r, r & `MAP1_VALID);
         wrc(`MAP2_OFS, r, r & `MAP2_VALID);
      end
      for (int b = 0; b < 24; b++) begin
         if (!vm[b] || b inside {[13:15]}) continue;
         d = dest_t'(b < 8 ? xs() % 2 : xs() % 8);
         ack <= 1'b1;
         bus(1'b1, `EN_OFS, 32'h1 << b);
         ack <= 1'b0;
         bus(1'b1, map_of(b), 32'(d) << (4 * (b % 8)));
         src[b] <= 1'b1;
         @(posedge mclk);
         src[b] <= 1'b0;
         repeat (3) @(posedge mclk);
         chk({24'h0, pins}, 32'h1 << d);
         chk({24'h0, seen}, 32'h1 << d);
         chk({31'h0, irq}, 32'h1);
         rdc(`STAT_OFS, 32'h1 << b);
         chk({24'h0, fok, 1'b0}, fok_of(b));
         wrc(`STAT_OFS, ~(32'h1 << b), 32'h1 << b);
         src[b] <= 1'b1;
         wrc(`STAT_OFS, 32'h1 << b, '0);
         src[b] <= 1'b0;
      end
      bus(1'b1, `EN_OFS, '0);
      src[8] <= 1'b1;
      repeat (4) @(posedge mclk);
      chk({31'h0, irq}, '0);
      rdc(`STAT_OFS, 32'h100);
      src[8] <= 1'b0;
      wrc(`STAT_OFS, 32'h100, '0);
      for (int b = 14; b < 16; b++) begin
         src[b] <= 1'b1;
         repeat (8) @(posedge mclk);
         wrc(`STAT_OFS, 32'h1 << b, 32'h1 << b);
         src[b] <= 1'b0;
         repeat (6) @(posedge mclk);
         wrc(`STAT_OFS, 32'h1 << b, '0);
      end
      bus(1'b1, `EN_OFS, 32'h2000);
      rdc(`STAT_OFS, 32'h2000);
      bus(1'b1, `MAP2_OFS, '0);
      be <= 4'h2;
      wrc(`MAP2_OFS, 32'hFFFFFFFF, 32'h00007700);
      be <= 4'hF;
      conclude();
   end
endmodule
